// *** hdl/asr_cfg.svh ***
// timing counts and widths for the one-bit static memory controller
// assumes a 200 MHz system clock driving the memory pins through flip-flops
`ifndef ASR_CFG_SVH
`define ASR_CFG_SVH
`define ASR_ADDR_W 18
`define ASR_WORDS 262144
`define ASR_CLK_PS 5000
// ps figures: read access, write pulse, recovery gap after each access
`define ASR_ACCESS_PS 20000
`define ASR_WP_PS 16000
`define ASR_REC_PS 3000
`define ASR_ACCESS_CYC ((`ASR_ACCESS_PS + `ASR_CLK_PS - 1) / `ASR_CLK_PS + 2)
`define ASR_WP_CYC ((`ASR_WP_PS + `ASR_CLK_PS - 1) / `ASR_CLK_PS)
`define ASR_REC_CYC ((`ASR_REC_PS + `ASR_CLK_PS - 1) / `ASR_CLK_PS)
`define ASR_CNT_W 4
`endif

// *** hdl/asr_pkg.sv ***
// types for the one-bit static memory controller
// assumes asr_cfg.svh is on the include path
`include "asr_cfg.svh"
package asr_pkg;
	typedef enum logic [4:0] {
		ASR_IDLE = 5'h01,
		ASR_SETUP = 5'h02,
		ASR_READ = 5'h04,
		ASR_WRITE = 5'h08,
		ASR_RECOVER = 5'h10
	} asr_state_t;

	typedef struct packed {
		logic device_select_n;
		logic write_strobe_n;
		logic write_bit_in;
		logic [`ASR_ADDR_W-1:0] word_select_lines;
	} asr_pins_t;

	typedef struct packed {
		asr_state_t st;
		logic [`ASR_CNT_W-1:0] cnt;
		logic is_write;
		logic busy;
		logic done;
		logic rdata;
		logic rsync1;
		logic rsync2;
		asr_pins_t pins;
	} asr_regs_t;
endpackage

// *** hdl/asr_ctrl.sv ***
// controller that drives a 256k x 1 asynchronous static memory over its pins
// assumes one request at a time; read data pin is sampled through two flip-flops
`timescale 1ns/1ps
`default_nettype none
`include "asr_cfg.svh"
module asr_ctrl
	import asr_pkg::*;
(
	input wire logic clk,
	input wire logic reset,
	input wire logic req_valid,
	input wire logic req_write,
	input wire logic [`ASR_ADDR_W-1:0] req_addr,
	input wire logic req_wdata,
	output logic req_ready,
	output logic rsp_valid,
	output logic rsp_rdata,
	output logic device_select_n,
	output logic write_strobe_n,
	output logic write_bit_in,
	output logic [`ASR_ADDR_W-1:0] word_select_lines,
	input wire logic read_bit_out
);
	localparam logic [`ASR_CNT_W-1:0] ACC_N = `ASR_CNT_W'(`ASR_ACCESS_CYC);
	localparam logic [`ASR_CNT_W-1:0] WP_N = `ASR_CNT_W'(`ASR_WP_CYC);
	localparam logic [`ASR_CNT_W-1:0] REC_N = `ASR_CNT_W'(`ASR_REC_CYC);

	asr_regs_t r;
	asr_regs_t next_r;

	always_comb
	begin
		next_r = r;
		next_r.done = 1'b0;
		// two-stage sync of the memory's output pin
		next_r.rsync1 = read_bit_out;
		next_r.rsync2 = r.rsync1;
		case (r.st)
			ASR_IDLE:
			begin
				if (req_valid)
				begin
					// address moves only while select is high
					next_r.pins.word_select_lines = req_addr;
					next_r.pins.write_bit_in = req_wdata;
					next_r.is_write = req_write;
					next_r.busy = 1'b1;
					next_r.st = ASR_SETUP;
				end
			end
			ASR_SETUP:
			begin
				next_r.pins.device_select_n = 1'b0;
				next_r.cnt = r.is_write ? WP_N : ACC_N;
				next_r.pins.write_strobe_n = ~r.is_write;
				next_r.st = r.is_write ? ASR_WRITE : ASR_READ;
			end
			ASR_READ:
			begin
				if (r.cnt <= `ASR_CNT_W'(1))
				begin
					next_r.rdata = r.rsync2;
					next_r.pins.device_select_n = 1'b1;
					next_r.done = 1'b1;
					next_r.cnt = REC_N;
					next_r.st = ASR_RECOVER;
				end
				else
				begin
					next_r.cnt = r.cnt - `ASR_CNT_W'(1);
				end
			end
			ASR_WRITE:
			begin
				if (r.cnt <= `ASR_CNT_W'(1))
				begin
					// strobe ends the write; data and address held through recovery
					next_r.pins.write_strobe_n = 1'b1;
					next_r.done = 1'b1;
					next_r.cnt = REC_N;
					next_r.st = ASR_RECOVER;
				end
				else
				begin
					next_r.cnt = r.cnt - `ASR_CNT_W'(1);
				end
			end
			ASR_RECOVER:
			begin
				next_r.pins.device_select_n = 1'b1;
				if (r.cnt <= `ASR_CNT_W'(1))
				begin
					next_r.busy = 1'b0;
					next_r.st = ASR_IDLE;
				end
				else
				begin
					next_r.cnt = r.cnt - `ASR_CNT_W'(1);
				end
			end
			default:
			begin
				next_r.st = ASR_IDLE;
				next_r.pins.device_select_n = 1'b1;
				next_r.pins.write_strobe_n = 1'b1;
			end
		endcase
	end

	// limitation: a reset in mid write raises the strobe in the same instant that address
	// and data clear, so the word under write is not protected
	always_ff @(posedge clk or posedge reset)
	begin
		if (reset)
		begin
			r.st <= ASR_IDLE;
			r.cnt <= '0;
			r.is_write <= 1'b0;
			r.busy <= 1'b0;
			r.done <= 1'b0;
			r.rdata <= 1'b0;
			r.rsync1 <= 1'b0;
			r.rsync2 <= 1'b0;
			r.pins.device_select_n <= 1'b1;
			r.pins.write_strobe_n <= 1'b1;
			r.pins.write_bit_in <= 1'b0;
			r.pins.word_select_lines <= '0;
		end
		else
		begin
			r <= next_r;
		end
	end

	// no refresh or keep-alive is ever issued while idle
	assign req_ready = (r.st == ASR_IDLE);
	assign rsp_valid = r.done;
	assign rsp_rdata = r.rdata;
	assign device_select_n = r.pins.device_select_n;
	assign write_strobe_n = r.pins.write_strobe_n;
	assign write_bit_in = r.pins.write_bit_in;
	assign word_select_lines = r.pins.word_select_lines;

	sequence s_write_pulse;
		!device_select_n && !write_strobe_n;
	endsequence

	// select held low with the strobe high for the whole access wait
	sequence s_read_sel;
		(!device_select_n && write_strobe_n)[*6];
	endsequence

	// select stays low one cycle past the strobe, then rises
	sequence s_write_end;
		!device_select_n ##1 device_select_n;
	endsequence

	a_read_strobe_high: assert property (@(posedge clk) disable iff (reset)
		(r.st == ASR_READ) |-> write_strobe_n)
		else $error("strobe low during read");
	a_addr_stable_write: assert property (@(posedge clk) disable iff (reset)
		s_write_pulse |=> $stable(word_select_lines) || (device_select_n || write_strobe_n))
		else $error("address moved in write");
	a_addr_before_select: assert property (@(posedge clk) disable iff (reset)
		$fell(device_select_n) |-> $stable(word_select_lines))
		else $error("address changed at select fall");
	a_idle_deselect: assert property (@(posedge clk) disable iff (reset)
		(r.st == ASR_IDLE) |-> device_select_n && write_strobe_n)
		else $error("select low while idle");
	a_write_len: assert property (@(posedge clk) disable iff (reset)
		$fell(write_strobe_n) |-> (!write_strobe_n)[*4] ##1 write_strobe_n)
		else $error("write pulse length wrong");
	a_write_data_hold: assert property (@(posedge clk) disable iff (reset)
		$rose(write_strobe_n) |-> $stable(write_bit_in) && $stable(word_select_lines))
		else $error("data moved at write end");
	a_read_done: assert property (@(posedge clk) disable iff (reset)
		$fell(device_select_n) && write_strobe_n |-> ##[1:8] rsp_valid)
		else $error("read answer late");
	a_deselect_end: assert property (@(posedge clk) disable iff (reset)
		rsp_valid && !r.is_write |-> device_select_n && write_strobe_n)
		else $error("select still low after read");

	a_read_window: assert property (@(posedge clk) disable iff (reset)
		$fell(device_select_n) && write_strobe_n |-> s_read_sel ##1 device_select_n)
		else $error("read select window wrong");

	a_write_end_order: assert property (@(posedge clk) disable iff (reset)
		$rose(write_strobe_n) |-> s_write_end)
		else $error("select not raised after write");

	a_strobe_in_select: assert property (@(posedge clk) disable iff (reset)
		!write_strobe_n |-> !device_select_n)
		else $error("strobe low while deselected");

	a_write_start: assert property (@(posedge clk) disable iff (reset)
		$fell(write_strobe_n) |-> $fell(device_select_n))
		else $error("write pulse began outside select");

	a_addr_hold_sel: assert property (@(posedge clk) disable iff (reset)
		!device_select_n |=> $stable(word_select_lines))
		else $error("address moved while selected");

	a_answer_pulse: assert property (@(posedge clk) disable iff (reset)
		rsp_valid |=> !rsp_valid)
		else $error("answer pulse too long");

	a_rdata_hold: assert property (@(posedge clk) disable iff (reset)
		!rsp_valid |-> $stable(rsp_rdata))
		else $error("read data moved without answer");
endmodule
`default_nettype wire

// *** bench/asr_mem_model.sv ***
// behavioural 256k x 1 static memory, the device on the controller's pins
// drives its released output itself to a changing level, the inverse of the last read bit
`timescale 1ns/1ps
`default_nettype none
`include "asr_cfg.svh"
module asr_mem_model
(
	input wire logic device_select_n,
	input wire logic write_strobe_n,
	input wire logic write_bit_in,
	input wire logic [`ASR_ADDR_W-1:0] word_select_lines,
	output logic read_bit_out
);
	logic mem [0:`ASR_WORDS-1];
	logic drv;
	logic last = 1'b0;
	logic wr_act = 1'b0;
	assign drv = !device_select_n && write_strobe_n;
	// released pin shows the inverse of the last bit so a stale value never passes
	assign read_bit_out = drv ? mem[word_select_lines] : ~last;
	always @*
		if (drv)
			last = mem[word_select_lines];
	// data latches at whichever of strobe or select rises first
	always @(device_select_n, write_strobe_n)
	begin
		if (wr_act && (device_select_n || write_strobe_n))
			mem[word_select_lines] = write_bit_in;
		wr_act = !device_select_n && !write_strobe_n;
	end
endmodule
`default_nettype wire

// *** bench/async_sram_256k_by_1_port_tb.sv ***
// self-checking bench for the static memory controller
// assumes the memory model sits on the pins; one request at a time
`timescale 1ns/1ps
`default_nettype none
`include "asr_cfg.svh"
module async_sram_256k_by_1_port_tb;
	import asr_pkg::*;
	logic clk = 1'b0;
	logic reset = 1'b1;
	logic req_valid = 1'b0;
	logic req_write = 1'b0;
	logic [17:0] req_addr = 18'h0;
	logic req_wdata = 1'b0;
	logic req_ready, rsp_valid, rsp_rdata, sel_n, stb_n, wbit, rbit;
	logic [17:0] addr;
	int fails = 0;
	int num_checks = 0;
	// writes first, then reads of the same words, so no read meets an unwritten word
	logic [19:0] rows [0:7] = '{20'hc0000, 20'hbffff, 20'hd2345, 20'h80001,
		20'h3ffff, 20'h52345, 20'h00001, 20'h40000};
	asr_ctrl DUT (.clk(clk), .reset(reset), .req_valid(req_valid), .req_write(req_write),
		.req_addr(req_addr), .req_wdata(req_wdata), .req_ready(req_ready),
		.rsp_valid(rsp_valid), .rsp_rdata(rsp_rdata), .device_select_n(sel_n),
		.write_strobe_n(stb_n), .write_bit_in(wbit), .word_select_lines(addr),
		.read_bit_out(rbit));
	asr_mem_model mem (.device_select_n(sel_n), .write_strobe_n(stb_n),
		.write_bit_in(wbit), .word_select_lines(addr), .read_bit_out(rbit));
	initial forever #2.5 clk = ~clk;
	task automatic chk(input string name, input logic [17:0] got, input logic [17:0] exp);
		num_checks++;
		if (got !== exp)
		begin
			fails++;
			$display("[ERR] %s expected %h seen %h", name, exp, got);
		end
	endtask
	task automatic conclude();
		if (fails == 0 && num_checks > 0)
			$display("*** PASS ***");
		else
			$display("*** FAIL ***");
		$finish;
	endtask
	// row: bit19 write, bit18 data or expected read bit, bits 17:0 address
	task automatic xfer(input logic w, input logic d, input logic [17:0] a);
		int n;
		int lo;
		@(negedge clk);
		n = 0;
		// ready moves only on a rising edge, so seen here it still stands at the take
		while (req_ready !== 1'b1 && n < 30)
		begin
			@(negedge clk);
			n++;
		end
		chk("ready", 18'(req_ready), 18'h1);
		req_valid = 1'b1;
		req_write = w;
		req_wdata = d;
		req_addr = a;
		@(negedge clk);
		req_valid = 1'b0;
		chk("busy", 18'(req_ready), 18'h0);
		n = 0;
		lo = 0;
		while (rsp_valid !== 1'b1 && n < 30)
		begin
			if (!w) chk("strobe", 18'(stb_n), 18'h1);
			if (sel_n === 1'b0) chk("addr", addr, a);
			if (sel_n === 1'b0) lo++;
			@(negedge clk);
			n++;
		end
		chk("done", 18'(rsp_valid), 18'h1);
		chk("sel_len", 18'(lo), w ? 18'(`ASR_WP_CYC) : 18'(`ASR_ACCESS_CYC));
		if (!w) chk("rdata", 18'(rsp_rdata), 18'(d));
		@(negedge clk);
		chk("pulse", 18'(rsp_valid), 18'h0);
	endtask
	initial
	begin
		repeat (2) @(negedge clk);
		chk("sel_rst", 18'(sel_n), 18'h1);
		chk("stb_rst", 18'(stb_n), 18'h1);
		chk("rdy_rst", 18'(req_ready), 18'h1);
		chk("rsp_rst", {16'h0, rsp_valid, rsp_rdata}, 18'h0);
		chk("addr_rst", addr, 18'h0);
		repeat (2) @(negedge clk);
		reset = 1'b0;
		for (int i = 0; i < 8; i++)
			xfer(rows[i][19], rows[i][18], rows[i][17:0]);
		// a write must leave the last read bit in place
		xfer(1'b1, 1'b0, 18'h0);
		chk("rhold", 18'(rsp_rdata), 18'h1);
		// idle gap, then the overwritten bit is still kept
		repeat (50) @(negedge clk);
		chk("idle_sel", 18'(sel_n), 18'h1);
		xfer(1'b0, 1'b0, 18'h0);
		// reset in mid write: both strobes rise together, then the controller starts clean
		@(negedge clk);
		req_valid = 1'b1;
		req_write = 1'b1;
		req_addr = 18'h2;
		@(negedge clk);
		req_valid = 1'b0;
		repeat (2) @(negedge clk);
		chk("mid_stb", 18'(stb_n), 18'h0);
		reset = 1'b1;
		@(negedge clk);
		chk("mid_sel", {16'h0, sel_n, stb_n}, 18'h3);
		chk("mid_rdy", 18'(req_ready), 18'h1);
		reset = 1'b0;
		xfer(1'b0, 1'b1, 18'h12345);
		conclude();
	end
	initial
	begin
		#10000;
		fails++;
		conclude();
	end
endmodule
`default_nettype wire
